// file: hw/rps_pkg.sv
package rps_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned NS_PER_MS      = 1000000;
  localparam int unsigned POR_HOLD_MS    = 110;
  // longest time: rounds down
  localparam int unsigned POR_HOLD_CYC   =
    (POR_HOLD_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned SDIO_WAIT_MS   = 150;
  // least time: rounds up
  localparam int unsigned SDIO_WAIT_CYC  =
    (SDIO_WAIT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_OFF_MS = 1;
  localparam int unsigned RECOVER_OFF_CYC =
    (RECOVER_OFF_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W          = 25;

  // general pins: 0..11 then 17, 18, 19 at positions 12..14
  localparam int GP_NUM      = 15;
  localparam int GP_IDX_DOWN = 0;
  localparam int GP_IDX_UP_A = 9;
  localparam int GP_IDX_UP_B = 11;

  // radio-section pads
  localparam int RP_NUM       = 16;
  localparam int RP_HOST_WAKE = 0;
  localparam int RP_DEV_WAKE  = 1;
  localparam int RP_GP_FOUR   = 2;
  localparam int RP_GP_FIVE   = 3;
  localparam int RP_CTS_N     = 4;
  localparam int RP_RTS_N     = 5;
  localparam int RP_RXD       = 6;
  localparam int RP_TXD       = 7;
  localparam int RP_VBCLK     = 8;
  localparam int RP_VSYNC     = 9;
  localparam int RP_VDIN      = 10;
  localparam int RP_VDOUT     = 11;
  localparam int RP_ABCLK     = 12;
  localparam int RP_AWS       = 13;
  localparam int RP_ADOUT     = 14;
  localparam int RP_ADIN      = 15;

  localparam int RF_W = 4;

  typedef enum logic [1:0] {
    PULL_NONE, PULL_UP, PULL_DOWN, PULL_DFLT
  } rps_pull_t;

  typedef struct packed {
    logic      drive;
    rps_pull_t pull;
  } rps_pad_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_POR, ST_PRE_FW, ST_ACTIVE, ST_SLEEP, ST_LAN_ONLY
  } rps_pwr_t;

  // values after reset
  localparam rps_pull_t CFG_RST      = PULL_DFLT;
  localparam rps_pad_t  PAD_RST      = '{drive: 1'b0, pull: PULL_NONE};
  localparam logic [1:0] EN_PULL_RST = 2'h3;

endpackage : rps_pkg

// file: hw/rps_if.sv
`timescale 1ns/100ps
interface rps_if;
  logic lan_section_enable;
  logic radio_section_enable;
  logic sdio_cmd_start;

  modport device (
    input lan_section_enable,
    input radio_section_enable,
    input sdio_cmd_start
  );
  modport host (
    output lan_section_enable,
    output radio_section_enable,
    output sdio_cmd_start
  );
endinterface : rps_if

// file: hw/rps_device.sv
// Contract
// - enable pull-downs on except programmable active/sleep
// - both enables low: pads float, pins 9/11 up
// - active/sleep general pins programmable, defaults per state
// - pre-firmware: pin0 down, 9/11 up, rf driven
// - clock request active high, open-drain outside active/sleep
// - lan-only radio pads held in fixed pulls
// - pre-firmware radio pads held in fixed pulls
// - host raises enables only after sleep clock stable
// - power-on reset hold at most 110 ms
// - host waits 150 ms before card-bus access
// - host power-cycles enables to recover
// - host drops enables before removing supplies
// - disabled section held in reset, independently
`timescale 1ns/100ps
module rps_device
  import rps_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYCLES = POR_HOLD_CYC
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // link to the host
  rps_if.device                 link,
  // firmware side status and programming
  input  wire logic             fw_loaded,
  input  wire logic             sleep_req,
  input  wire logic             cfg_we,
  input  wire logic [3:0]       cfg_idx,
  input  wire rps_pull_t        cfg_pull,
  input  wire logic [GP_NUM-1:0] gp_dir_out,
  input  wire logic             en_pull_off,
  input  wire logic             clk_req_push_pull,
  input  wire logic             clk_req_level,
  input  wire logic [RF_W-1:0]  rf_switch_value,
  input  wire logic             early_access_clr,
  // state and section resets
  output rps_pwr_t              pwr_state_ff,
  output logic                  lan_rst_n_ff,
  output logic                  radio_rst_n_ff,
  output logic                  early_access_ff,
  // enable input pull-downs (lan, radio)
  output logic [1:0]            en_pull_down_ff,
  // pad attributes
  output rps_pad_t              gp_pad_ff    [GP_NUM],
  output rps_pad_t              radio_pad_ff [RP_NUM],
  output logic                  rf_drive_ff,
  output logic [RF_W-1:0]       rf_out_ff,
  output logic                  clk_req_out_ff,
  output logic                  clk_req_oe_ff,
  output logic                  clk_req_od_ff
);

  // general pin default pull per power state
  function automatic rps_pull_t gp_dflt(rps_pwr_t st, int idx);
    rps_pull_t p;
    p = PULL_NONE;
    case (st)
      ST_ACTIVE: begin
        if (idx == GP_IDX_DOWN) p = PULL_DOWN;
        else if (idx == GP_IDX_UP_A || idx == GP_IDX_UP_B) p = PULL_UP;
      end
      ST_SLEEP: begin
        if (idx == GP_IDX_DOWN) p = PULL_DOWN;
        else if (idx == GP_IDX_UP_B) p = PULL_UP;
      end
      ST_OFF: begin
        if (idx == GP_IDX_UP_A || idx == GP_IDX_UP_B) p = PULL_UP;
      end
      default: begin
        if (idx == GP_IDX_DOWN) p = PULL_DOWN;
        else if (idx == GP_IDX_UP_A || idx == GP_IDX_UP_B) p = PULL_UP;
      end
    endcase
    return p;
  endfunction : gp_dflt

  // radio pad attribute per power state
  function automatic rps_pad_t rp_cfg(rps_pwr_t st, int idx);
    rps_pad_t r;
    r.drive = 1'b0;
    r.pull  = PULL_NONE;
    case (st)
      ST_OFF: begin
        r.pull = PULL_NONE;
      end
      ST_ACTIVE, ST_SLEEP: begin
        r.drive = (idx == RP_HOST_WAKE) || (idx == RP_RTS_N) ||
                  (idx == RP_TXD) || (idx == RP_ADOUT);
      end
      default: begin
        if (idx == RP_ABCLK || idx == RP_AWS) begin
          r.pull = PULL_NONE;
        end else if (idx == RP_DEV_WAKE || idx >= RP_VBCLK) begin
          r.pull = PULL_DOWN;
        end else begin
          r.pull = PULL_UP;
        end
        if (st == ST_LAN_ONLY && idx == RP_HOST_WAKE) begin
          r.pull = PULL_DOWN;
        end
      end
    endcase
    return r;
  endfunction : rp_cfg

  // enable decode
  wire logic       lan_en     = link.lan_section_enable;
  wire logic       radio_en   = link.radio_section_enable;
  wire logic       any_en     = lan_en | radio_en;
  wire logic       prog_state = (pwr_state_ff == ST_ACTIVE) ||
                                (pwr_state_ff == ST_SLEEP);

  // power-on reset hold counter
  logic [CNT_W-1:0] por_cnt_ff;
  logic             por_done_ff;
  wire logic        por_last = (por_cnt_ff == CNT_W'(POR_HOLD_CYCLES - 1));
  wire logic [CNT_W-1:0] nxt_por_cnt =
    (!any_en || por_done_ff) ? '0 : por_cnt_ff + CNT_W'(1);
  wire logic        nxt_por_done = any_en & (por_done_ff | por_last);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      por_cnt_ff  <= '0;
      por_done_ff <= 1'b0;
    end else begin
      por_cnt_ff  <= nxt_por_cnt;
      por_done_ff <= nxt_por_done;
    end
  end

  // power state from enables, reset and firmware status
  rps_pwr_t nxt_pwr_state;
  always_comb begin
    if (!any_en)                nxt_pwr_state = ST_OFF;
    else if (lan_en && !radio_en) nxt_pwr_state = ST_LAN_ONLY;
    else if (!por_done_ff)      nxt_pwr_state = ST_POR;
    else if (!fw_loaded)        nxt_pwr_state = ST_PRE_FW;
    else if (sleep_req)         nxt_pwr_state = ST_SLEEP;
    else                        nxt_pwr_state = ST_ACTIVE;
  end

  // section resets follow own enable and the reset hold
  wire logic nxt_lan_rst_n   = lan_en & por_done_ff;
  wire logic nxt_radio_rst_n = radio_en & por_done_ff;

  // access while lan section still in reset; set wins over clear
  wire logic early_hit = link.sdio_cmd_start & ~lan_rst_n_ff;
  wire logic nxt_early = early_hit | (early_access_ff & ~early_access_clr);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pwr_state_ff    <= ST_OFF;
      lan_rst_n_ff    <= 1'b0;
      radio_rst_n_ff  <= 1'b0;
      early_access_ff <= 1'b0;
    end else begin
      pwr_state_ff    <= nxt_pwr_state;
      lan_rst_n_ff    <= nxt_lan_rst_n;
      radio_rst_n_ff  <= nxt_radio_rst_n;
      early_access_ff <= nxt_early;
    end
  end

  // enable pull-downs only drop when programmed in active/sleep
  wire logic [1:0] nxt_en_pull = (prog_state && en_pull_off) ?
                                 2'h0 : EN_PULL_RST;

  always_ff @(posedge sys_clk) begin
    if (!resetn) en_pull_down_ff <= EN_PULL_RST;
    else         en_pull_down_ff <= nxt_en_pull;
  end

  // general pins: programmed pull store and pad attributes
  rps_pull_t gp_cfg_ff [GP_NUM];

  for (genvar i = 0; i < GP_NUM; i++) begin : g_gp
    wire logic      wr_hit  = cfg_we && (cfg_idx == 4'(i));
    wire rps_pull_t dflt    = gp_dflt(pwr_state_ff, i);
    wire rps_pull_t eff     = (prog_state && gp_cfg_ff[i] != PULL_DFLT) ?
                              gp_cfg_ff[i] : dflt;
    wire rps_pad_t  nxt_pad = '{drive: prog_state & gp_dir_out[i],
                                pull:  eff};

    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        gp_cfg_ff[i] <= CFG_RST;
        gp_pad_ff[i] <= PAD_RST;
      end else begin
        if (wr_hit) gp_cfg_ff[i] <= cfg_pull;
        gp_pad_ff[i] <= nxt_pad;
      end
    end
  end

  // radio pads fixed per state outside active/sleep
  for (genvar j = 0; j < RP_NUM; j++) begin : g_rp
    wire rps_pad_t nxt_pad = rp_cfg(pwr_state_ff, j);

    always_ff @(posedge sys_clk) begin
      if (!resetn) radio_pad_ff[j] <= PAD_RST;
      else         radio_pad_ff[j] <= nxt_pad;
    end
  end

  // rf switch lines driven whenever any section is up
  wire logic            nxt_rf_drive = (pwr_state_ff != ST_OFF);
  wire logic [RF_W-1:0] nxt_rf_out   = nxt_rf_drive ?
                                       rf_switch_value : '0;

  // clock request: push-pull only when programmed in active/sleep
  wire logic nxt_cr_pp  = prog_state & clk_req_push_pull;
  wire logic nxt_cr_on  = (pwr_state_ff != ST_OFF) &&
                          (pwr_state_ff != ST_POR);
  wire logic nxt_cr_oe  = nxt_cr_on & (nxt_cr_pp | ~clk_req_level);
  wire logic nxt_cr_out = nxt_cr_on & nxt_cr_pp & clk_req_level;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rf_drive_ff    <= 1'b0;
      rf_out_ff      <= '0;
      clk_req_out_ff <= 1'b0;
      clk_req_oe_ff  <= 1'b0;
      clk_req_od_ff  <= 1'b1;
    end else begin
      rf_drive_ff    <= nxt_rf_drive;
      rf_out_ff      <= nxt_rf_out;
      clk_req_out_ff <= nxt_cr_out;
      clk_req_oe_ff  <= nxt_cr_oe;
      clk_req_od_ff  <= ~nxt_cr_pp;
    end
  end

endmodule : rps_device

// file: hw/rps_host.sv
`timescale 1ns/100ps
module rps_host
  import rps_pkg::*;
#(
  parameter int unsigned SDIO_WAIT_CYCLES   = SDIO_WAIT_CYC,
  parameter int unsigned RECOVER_OFF_CYCLES = RECOVER_OFF_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // link to the device
  rps_if.host       link,
  // user requests
  input  wire logic sleep_clock_stable,
  input  wire logic lan_want,
  input  wire logic radio_want,
  input  wire logic recover_req,
  input  wire logic sdio_req,
  // user status
  output logic      sdio_ready_ff,
  output logic      sdio_refused_ff,
  output logic      recovering_ff,
  output logic      supplies_off_ok_ff
);

  typedef enum logic [1:0] {H_WAIT_CLK, H_RUN, H_CYCLE_OFF} rps_hst_t;

  rps_hst_t         state_ff;
  logic             lan_en_ff;
  logic             radio_en_ff;
  logic             cmd_ff;
  logic [CNT_W-1:0] wait_cnt_ff;
  logic [CNT_W-1:0] off_cnt_ff;

  // sequencing: enables stay low until the sleep clock is stable
  wire logic off_done = (off_cnt_ff == CNT_W'(RECOVER_OFF_CYCLES - 1));
  rps_hst_t nxt_state;
  always_comb begin
    case (state_ff)
      H_WAIT_CLK:  nxt_state = sleep_clock_stable ? H_RUN : H_WAIT_CLK;
      H_RUN:       nxt_state = recover_req ? H_CYCLE_OFF : H_RUN;
      H_CYCLE_OFF: nxt_state = off_done ? H_WAIT_CLK : H_CYCLE_OFF;
      default:     nxt_state = H_WAIT_CLK;
    endcase
  end

  wire logic run       = (nxt_state == H_RUN);
  wire logic nxt_lan   = run & lan_want;
  wire logic nxt_radio = run & radio_want;
  wire logic [CNT_W-1:0] nxt_off =
    (state_ff == H_CYCLE_OFF) ? off_cnt_ff + CNT_W'(1) : '0;

  // card-bus gate: counts from the lan enable rising
  wire logic wait_full = (wait_cnt_ff >= CNT_W'(SDIO_WAIT_CYCLES));
  wire logic [CNT_W-1:0] nxt_wait =
    !lan_en_ff ? '0 : (wait_full ? wait_cnt_ff : wait_cnt_ff + CNT_W'(1));
  wire logic nxt_ready = nxt_lan & lan_en_ff & wait_full;
  wire logic nxt_cmd   = sdio_req & sdio_ready_ff & nxt_lan;
  wire logic nxt_ref   = sdio_req & ~nxt_cmd;
  wire logic nxt_offok = ~nxt_lan & ~nxt_radio;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff           <= H_WAIT_CLK;
      lan_en_ff          <= 1'b0;
      radio_en_ff        <= 1'b0;
      cmd_ff             <= 1'b0;
      wait_cnt_ff        <= '0;
      off_cnt_ff         <= '0;
      sdio_ready_ff      <= 1'b0;
      sdio_refused_ff    <= 1'b0;
      recovering_ff      <= 1'b0;
      supplies_off_ok_ff <= 1'b1;
    end else begin
      state_ff           <= nxt_state;
      lan_en_ff          <= nxt_lan;
      radio_en_ff        <= nxt_radio;
      cmd_ff             <= nxt_cmd;
      wait_cnt_ff        <= nxt_wait;
      off_cnt_ff         <= nxt_off;
      sdio_ready_ff      <= nxt_ready;
      sdio_refused_ff    <= nxt_ref;
      recovering_ff      <= (nxt_state == H_CYCLE_OFF);
      supplies_off_ok_ff <= nxt_offok;
    end
  end

  // link drive
  assign link.lan_section_enable   = lan_en_ff;
  assign link.radio_section_enable = radio_en_ff;
  assign link.sdio_cmd_start       = cmd_ff;

endmodule : rps_host

// file: dv/rps_props.sv
`timescale 1ns/100ps
module rps_props
  import rps_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYCLES  = POR_HOLD_CYC,
  parameter int unsigned SDIO_WAIT_CYCLES = SDIO_WAIT_CYC
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       resetn,
  // link between the two ends
  input wire logic       lan_section_enable,
  input wire logic       radio_section_enable,
  input wire logic       sdio_cmd_start,
  // status beside the link
  input wire logic       sleep_clock_stable,
  input wire logic       supplies_off_ok_ff,
  input wire rps_pwr_t   pwr_state_ff,
  input wire logic       lan_rst_n_ff,
  input wire logic       radio_rst_n_ff,
  input wire logic [1:0] en_pull_down_ff,
  input wire logic       clk_req_od_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  int unsigned lan_cnt_ff;
  int unsigned on_cnt_ff;
  logic        fixed_st;
  logic        any_on;
  assign fixed_st = pwr_state_ff != ST_ACTIVE && pwr_state_ff != ST_SLEEP;
  assign any_on   = lan_section_enable || radio_section_enable;

  // cycles since lan enable rose and since either enable rose
  always_ff @(posedge sys_clk) begin
    lan_cnt_ff <= (resetn && lan_section_enable) ? lan_cnt_ff + 1 : 0;
    on_cnt_ff  <= (resetn && any_on) ? on_cnt_ff + 1 : 0;
  end

  start_wait_a : assert property (
    sdio_cmd_start |-> lan_cnt_ff >= SDIO_WAIT_CYCLES)
    else $error("card access too soon after lan enable");
  lan_rise_a : assert property (
    $rose(lan_section_enable) |-> sleep_clock_stable)
    else $error("lan enable raised before sleep clock");
  radio_rise_a : assert property (
    $rose(radio_section_enable) |-> sleep_clock_stable)
    else $error("radio enable raised before sleep clock");
  por_hold_a : assert property (
    $rose(lan_rst_n_ff) || $rose(radio_rst_n_ff)
    |-> on_cnt_ff <= POR_HOLD_CYCLES + 3)
    else $error("reset hold too long");
  lan_hold_a : assert property (
    !lan_section_enable [*3] |-> !lan_rst_n_ff)
    else $error("lan section out of reset while disabled");
  radio_hold_a : assert property (
    !radio_section_enable [*3] |-> !radio_rst_n_ff)
    else $error("radio section out of reset while disabled");
  en_pull_a : assert property (
    fixed_st [*2] |-> en_pull_down_ff == 2'h3)
    else $error("enable pull-down off outside active or sleep");
  od_fixed_a : assert property (
    (pwr_state_ff == ST_PRE_FW || pwr_state_ff == ST_LAN_ONLY) [*2]
    |-> clk_req_od_ff)
    else $error("clock request not open-drain");
  off_ok_a : assert property (
    (!lan_section_enable && !radio_section_enable) [*3]
    |-> supplies_off_ok_ff)
    else $error("supply-off permission missing");

  // main scenarios
  cover property (sdio_cmd_start);
  cover property ($rose(lan_rst_n_ff));
  cover property (pwr_state_ff == ST_LAN_ONLY);
endmodule : rps_props

// file: dv/rps_tb_top.sv
`timescale 1ns/100ps
module rps_tb_top
  import rps_pkg::*;
;
  localparam int unsigned POR_N  = 20;
  localparam int unsigned SDIO_N = 30;
  // stimulus
  logic sys_clk = 1'b0, resetn = 1'b0, sleep_clock_stable = 1'b0;
  logic lan_want = 1'b1, radio_want = 1'b1, recover_req = 1'b0;
  logic sdio_req = 1'b0, fw_loaded = 1'b0, sleep_req = 1'b0, cfg_we = 1'b0;
  logic en_pull_off = 1'b0, clk_req_push_pull = 1'b0;
  logic clk_req_level = 1'b0, early_access_clr = 1'b0;
  logic [3:0] cfg_idx = 4'h0;
  rps_pull_t cfg_pull = PULL_DFLT;
  logic [GP_NUM-1:0] gp_dir_out = 15'h0000;
  logic [RF_W-1:0] rf_switch_value = 4'h5;
  // observed
  rps_pwr_t pwr_state_ff;
  logic lan_rst_n_ff, radio_rst_n_ff, early_access_ff, rf_drive_ff;
  logic [1:0] en_pull_down_ff;
  rps_pad_t gp_pad_ff [GP_NUM];
  rps_pad_t radio_pad_ff [RP_NUM];
  logic [RF_W-1:0] rf_out_ff;
  logic clk_req_out_ff, clk_req_oe_ff, clk_req_od_ff;
  logic sdio_ready_ff, sdio_refused_ff, recovering_ff, supplies_off_ok_ff;
  int error_cnt = 0;
  int comparisons = 0;
  int cnt;

  // clock
  always #4 sys_clk = ~sys_clk;

  rps_if i_rps_if ();
  rps_device #(.POR_HOLD_CYCLES(POR_N)) i_rps_device (.sys_clk, .resetn,
    .link(i_rps_if.device), .fw_loaded, .sleep_req, .cfg_we, .cfg_idx,
    .cfg_pull, .gp_dir_out, .en_pull_off, .clk_req_push_pull,
    .clk_req_level, .rf_switch_value, .early_access_clr, .pwr_state_ff,
    .lan_rst_n_ff, .radio_rst_n_ff, .early_access_ff, .en_pull_down_ff,
    .gp_pad_ff, .radio_pad_ff, .rf_drive_ff, .rf_out_ff, .clk_req_out_ff,
    .clk_req_oe_ff, .clk_req_od_ff);
  rps_host #(.SDIO_WAIT_CYCLES(SDIO_N), .RECOVER_OFF_CYCLES(5)) i_rps_host (
    .sys_clk, .resetn, .link(i_rps_if.host), .sleep_clock_stable,
    .lan_want, .radio_want, .recover_req, .sdio_req, .sdio_ready_ff,
    .sdio_refused_ff, .recovering_ff, .supplies_off_ok_ff);
  rps_props #(.POR_HOLD_CYCLES(POR_N), .SDIO_WAIT_CYCLES(SDIO_N)) i_rps_props (
    .sys_clk, .resetn,
    .lan_section_enable(i_rps_if.lan_section_enable),
    .radio_section_enable(i_rps_if.radio_section_enable),
    .sdio_cmd_start(i_rps_if.sdio_cmd_start), .sleep_clock_stable,
    .supplies_off_ok_ff, .pwr_state_ff, .lan_rst_n_ff, .radio_rst_n_ff,
    .en_pull_down_ff, .clk_req_od_ff);

  // compare helpers
  task automatic chk_val(input logic [7:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val
  task automatic chk_state(input rps_pwr_t got, exp);
    chk_val(8'(got), 8'(exp), "power state");
  endtask : chk_state
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic wait_state(input rps_pwr_t s);
    #1;
    for (int k = 0; k < 100 && pwr_state_ff !== s; k++) step(1);
    chk_state(pwr_state_ff, s);
  endtask : wait_state

  // expected pulls per state
  function automatic rps_pull_t gp_exp(input int i, input rps_pwr_t st);
    if (i == GP_IDX_UP_B || (i == GP_IDX_UP_A && st != ST_SLEEP))
      return PULL_UP;
    if (i == GP_IDX_DOWN && st != ST_OFF) return PULL_DOWN;
    return PULL_NONE;
  endfunction : gp_exp
  function automatic rps_pull_t rp_exp(input int i, input bit lan_only);
    case (i)
      RP_HOST_WAKE: return lan_only ? PULL_DOWN : PULL_UP;
      RP_GP_FOUR, RP_GP_FIVE, RP_CTS_N, RP_RTS_N, RP_RXD, RP_TXD:
        return PULL_UP;
      RP_ABCLK, RP_AWS: return PULL_NONE;
      default: return PULL_DOWN;
    endcase
  endfunction : rp_exp
  task automatic chk_pads(input rps_pwr_t st);
    rps_pull_t e;
    bit prog;
    bit fix;
    prog = st inside {ST_ACTIVE, ST_SLEEP};
    fix = st inside {ST_OFF, ST_PRE_FW, ST_LAN_ONLY};
    for (int i = 0; i < GP_NUM; i++) begin
      e = (prog && i == 1) ? PULL_UP : gp_exp(i, st);
      chk_val(8'(gp_pad_ff[i].pull), 8'(e), "gp pull");
      chk_val(8'(gp_pad_ff[i].drive), 8'(prog & gp_dir_out[i]), "gp dir");
    end
    for (int i = 0; i < RP_NUM; i++) if (fix) begin
      e = (st == ST_OFF) ? PULL_NONE : rp_exp(i, st == ST_LAN_ONLY);
      chk_val(8'(radio_pad_ff[i].pull), 8'(e), "radio pull");
      chk_val(8'(radio_pad_ff[i].drive), 8'h0, "radio dir");
    end
  endtask : chk_pads
  task automatic sdio_pulse();
    @(posedge sys_clk) sdio_req <= 1'b1;
    @(posedge sys_clk) sdio_req <= 1'b0;
    #1;
  endtask : sdio_pulse

  // verdict
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // test sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    step(3);
    chk_state(pwr_state_ff, ST_OFF);
    chk_pads(ST_OFF);
    chk_val(8'(i_rps_if.lan_section_enable), 8'h0, "early enable");
    chk_val(8'(en_pull_down_ff), 8'h3, "enable pull-down");
    chk_val(8'(lan_rst_n_ff), 8'h0, "lan reset");
    chk_val(8'(clk_req_oe_ff), 8'h0, "clock request oe");
    chk_val(8'(rf_drive_ff), 8'h0, "rf drive");
    chk_val(8'(rf_out_ff), 8'h0, "rf out");
    $display("test power-down done");
    @(posedge sys_clk) sleep_clock_stable <= 1'b1;
    step(3);
    sdio_pulse();
    chk_val(8'(sdio_refused_ff), 8'h1, "refused");
    chk_val(8'(i_rps_if.sdio_cmd_start), 8'h0, "early start");
    for (cnt = 0; cnt < POR_N + 10 && lan_rst_n_ff !== 1'b1; cnt++) step(1);
    chk_val(8'(lan_rst_n_ff), 8'h1, "lan out of reset");
    chk_val(8'(radio_rst_n_ff), 8'h1, "radio out of reset");
    wait_state(ST_PRE_FW);
    step(2);
    chk_pads(ST_PRE_FW);
    chk_val(8'(rf_drive_ff), 8'h1, "rf drive");
    chk_val(8'(clk_req_od_ff), 8'h1, "clock request od");
    chk_val(8'(rf_out_ff), 8'h5, "rf out");
    chk_val(8'(clk_req_oe_ff), 8'h1, "clock request oe");
    chk_val(8'(clk_req_out_ff), 8'h0, "clock request out");
    for (cnt = 0; cnt < 100 && sdio_ready_ff !== 1'b1; cnt++) step(1);
    chk_val(8'(sdio_ready_ff), 8'h1, "card access ready");
    sdio_pulse();
    chk_val(8'(i_rps_if.sdio_cmd_start), 8'h1, "start");
    chk_val(8'(early_access_ff), 8'h0, "early access");
    $display("test pre-firmware done");
    @(posedge sys_clk) begin
      fw_loaded <= 1'b1;
      cfg_we <= 1'b1;
      cfg_idx <= 4'h1;
      cfg_pull <= PULL_UP;
      gp_dir_out <= 15'h0002;
      en_pull_off <= 1'b1;
      clk_req_push_pull <= 1'b1;
      clk_req_level <= 1'b1;
    end
    @(posedge sys_clk) cfg_we <= 1'b0;
    wait_state(ST_ACTIVE);
    step(2);
    chk_pads(ST_ACTIVE);
    chk_val(8'(en_pull_down_ff), 8'h0, "enable pull-down");
    chk_val(8'(clk_req_od_ff), 8'h0, "clock request od");
    chk_val(8'(clk_req_out_ff), 8'h1, "clock request out");
    chk_val(8'(clk_req_oe_ff), 8'h1, "clock request oe");
    @(posedge sys_clk) sleep_req <= 1'b1;
    wait_state(ST_SLEEP);
    step(2);
    chk_pads(ST_SLEEP);
    $display("test active and sleep done");
    @(posedge sys_clk) begin
      sleep_req <= 1'b0;
      radio_want <= 1'b0;
    end
    wait_state(ST_LAN_ONLY);
    step(2);
    chk_pads(ST_LAN_ONLY);
    chk_val(8'(clk_req_od_ff), 8'h1, "clock request od");
    chk_val(8'(clk_req_oe_ff), 8'h0, "clock request oe");
    chk_val(8'(en_pull_down_ff), 8'h3, "enable pull-down");
    chk_val(8'(radio_rst_n_ff), 8'h0, "radio reset");
    chk_val(8'(lan_rst_n_ff), 8'h1, "lan reset");
    $display("test lan-only done");
    @(posedge sys_clk) recover_req <= 1'b1;
    @(posedge sys_clk) recover_req <= 1'b0;
    step(3);
    chk_val(8'(i_rps_if.lan_section_enable), 8'h0, "recover off");
    chk_val(8'(supplies_off_ok_ff), 8'h1, "supplies off ok");
    chk_val(8'(recovering_ff), 8'h1, "recovering");
    chk_val(8'(lan_rst_n_ff), 8'h0, "lan reset");
    for (cnt = 0; cnt < 50 && i_rps_if.lan_section_enable !== 1'b1; cnt++)
      step(1);
    chk_val(8'(i_rps_if.lan_section_enable), 8'h1, "recover on");
    $display("test recovery done");
    finish_test();
  end
endmodule : rps_tb_top
